//--- rtl/liu_pkg.sv
package liu_pkg;
  // channel count and register port widths
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 4'h8;
  // status field layout, one byte lane per channel
  localparam int STAT_CH_STRIDE = 8;
  localparam int STAT_LOS_BIT = 0;
  localparam int STAT_LOL_BIT = 1;
  localparam int STAT_TX_LOCK_LOST_BIT_BIT = 2;
  localparam int STAT_FIFOERR_BIT = 3;
  localparam int STAT_IRQ_BIT = 4;
  // interrupt enable layout and reset value (tx lock loss only)
  localparam int EN_TX_LOCK_LOST_BIT_BIT = 0;
  localparam int EN_FIFOERR_BIT = 1;
  localparam int EN_W = 2;
  localparam logic [EN_W-1:0] IRQ_EN_RESET = 2'h1;
  // mode readback layout
  localparam int MODE_TXMODE_LSB = 0;
  localparam int MODE_FIFO_PHASE_RESET_LSB = 4;
  localparam int MODE_LPBK_LSB = 8;
  localparam int MODE_LPBK_STRIDE = 2;
  // frequency check limits
  localparam int PPM_LIMIT = 100;
  localparam int PPM_SCALE = 1_000_000;
  // cycles a three-level pin must stay put before it is applied
  localparam int DEBOUNCE_CYCLES = 4;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // decoded level of a three-level pin
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00,
    LVL_FLOAT = 2'b01,
    LVL_HIGH = 2'b10
  } tri_level_type;

  // transmit input method
  typedef enum logic [2:0] {
    PAR_SLAVE = 3'b000,
    PAR_LOOP = 3'b001,
    PAR_MASTER = 3'b010,
    SER_SYNC_CLK = 3'b011,
    SER_SYNC_CDR = 3'b100,
    SER_PLESIO = 3'b101
  } tx_mode_type;
endpackage

//--- rtl/tri_level_filter.sv
`timescale 1ns/1ns
module tri_level_filter
  import liu_pkg::*;
#(
  parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
)
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic sense_pu_in,
  input wire logic sense_pd_in,
  output tri_level_type level_out
);
  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  tri_level_type raw_d; // level seen this cycle
  tri_level_type cand_q; // candidate level being timed
  tri_level_type level_q; // applied level
  logic [CNT_W-1:0] cnt_q; // cycles candidate has held
  logic raw_ok; // sense pair forms a legal code

  // pulled up and pulled down sense: both low, both high, or follows the pull
  always_comb
  begin
    raw_ok = 1'b1;
    raw_d = LVL_FLOAT;
    if (!sense_pu_in && !sense_pd_in)
      raw_d = LVL_LOW;
    else if (sense_pu_in && sense_pd_in)
      raw_d = LVL_HIGH;
    else if (sense_pu_in && !sense_pd_in)
      raw_d = LVL_FLOAT;
    else
      raw_ok = 1'b0; // contradictory sense, ignored
  end

  // level applied only after it stays unchanged long enough
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cand_q <= LVL_FLOAT;
      cnt_q <= CNT_ZERO;
      level_q <= LVL_FLOAT;
    end
    else if (raw_ok && raw_d != cand_q)
    begin
      cand_q <= raw_d; // restart timing on any change
      cnt_q <= CNT_ZERO;
    end
    else if (raw_ok && cnt_q == CNT_LAST)
      level_q <= cand_q; // stable, apply
    else if (raw_ok)
      cnt_q <= cnt_q + 1'b1;
  end

  assign level_out = level_q;
endmodule // tri_level_filter

//--- rtl/liu_pin_mode_status_control.sv
// Operation
// - per-channel loss of signal output
// - loss of lock beyond 100 ppm
// - active-low transmit fault interrupt per channel
// - release on status read, reset, lock regain
// - default interrupt source is transmit lock loss
// - receive fault interrupts held inactive high
// - low reset input holds all logic reset
// - fifo reset centres pointers, clears error
// - fifo resumes from centre on release
// - fifo reset pin: low ch1, high ch2
// - fifo reset ignored in plesiochronous serial
// - loopback float routes receive to transmit
// - loopback high feeds transmit into receiver
// - parallel clock mode: slave, loop, master
// - serial low: external clock, through fifo
// - serial float: recovered clock, through fifo
// - serial high: recovered clock, fifo bypassed
// - width select high parallel, low serial
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module liu_pin_mode_status_control
  import liu_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int WIN_CYCLES = 100_000,
  parameter int EXPECT_EDGES = 100_000,
  parameter int FIFO_AW = 3
)
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic fifo_phase_reset_pu_in,
  input wire logic fifo_phase_reset_pd_in,
  input wire logic tx_clock_mode_select_pu_in,
  input wire logic tx_clock_mode_select_pd_in,
  input wire logic [CHANNELS-1:0] loopback_select_pu_in,
  input wire logic [CHANNELS-1:0] loopback_select_pd_in,
  input wire logic data_width_select_in,
  input wire logic [CHANNELS-1:0] rx_signal_lost_in,
  input wire logic [CHANNELS-1:0] rx_clk_edge_in,
  input wire logic [CHANNELS-1:0] tx_clk_edge_in,
  input wire logic [CHANNELS-1:0] fifo_wr_in,
  input wire logic [CHANNELS-1:0] fifo_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic [CHANNELS-1:0] rx_signal_lost_out,
  output logic [CHANNELS-1:0] rx_lock_lost_out,
  output logic [CHANNELS-1:0] tx_fault_irq_n_out,
  output logic [CHANNELS-1:0] rx_fault_irq_n_out,
  output logic [CHANNELS-1:0] fifo_phase_reset_out,
  output logic [CHANNELS-1:0] remote_loopback_out,
  output logic [CHANNELS-1:0] local_loopback_out,
  output tx_mode_type tx_mode_out,
  output logic fifo_bypass_out,
  output logic par_clk_drive_out,
  output logic loop_timing_out
);
  // measurement sizes
  localparam int NSRC = 2 * CHANNELS;
  localparam int WIN_W = $clog2(WIN_CYCLES + 1);
  localparam int TOL = EXPECT_EDGES * PPM_LIMIT / PPM_SCALE;
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYCLES - 1);
  localparam logic [WIN_W-1:0] EDGE_HI = WIN_W'(EXPECT_EDGES + TOL);
  localparam logic [WIN_W-1:0] EDGE_LO = WIN_W'(EXPECT_EDGES - TOL);
  localparam logic [WIN_W-1:0] WIN_ZERO = '0;
  // fifo pointer centre positions
  localparam logic [FIFO_AW-1:0] PTR_ZERO = '0;
  localparam logic [FIFO_AW-1:0] WR_CENTRE = FIFO_AW'(1 << (FIFO_AW - 1));

  tri_level_type fifo_phase_reset_lvl; // decoded fifo reset pin
  tri_level_type tx_clock_mode_select_lvl; // decoded clock mode pin
  tri_level_type lpbk_lvl [CHANNELS]; // decoded loopback pins
  logic [WIN_W-1:0] win_q; // measurement window counter
  logic win_end; // last cycle of a window
  logic [NSRC-1:0] edge_all; // rx edges low, tx edges high
  logic [NSRC-1:0] lol_q; // lock lost per source
  logic [CHANNELS-1:0] fifo_phase_reset_req; // fifo reset asked per channel
  logic [CHANNELS-1:0] fifo_phase_reset_q; // fifo reset applied
  logic [CHANNELS-1:0] fifo_err_q; // sticky fifo error flag
  logic [CHANNELS-1:0] fifo_cause_q; // interrupt raised by fifo error
  logic [CHANNELS-1:0] irq_q; // interrupt pending
  logic [CHANNELS-1:0] tx_lock_lost_bit_prev_q; // tx lock lost one cycle ago
  logic [CHANNELS-1:0] err_prev_q; // fifo error one cycle ago
  logic [CHANNELS-1:0] los_q; // registered loss of signal
  logic [EN_W-1:0] irq_en_q; // interrupt source enables
  logic [DATA_W-1:0] rdata_q; // read data register
  logic [DATA_W-1:0] rdata_d;
  tx_mode_type mode_q; // applied transmit mode
  tx_mode_type mode_d;
  logic stat_rd; // status read this cycle

  // three-level pins, one filter each
  tri_level_filter u_fifo_phase_reset (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sense_pu_in(fifo_phase_reset_pu_in),
    .sense_pd_in(fifo_phase_reset_pd_in),
    .level_out(fifo_phase_reset_lvl)
  );
  tri_level_filter u_tx_clock_mode_select (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sense_pu_in(tx_clock_mode_select_pu_in),
    .sense_pd_in(tx_clock_mode_select_pd_in),
    .level_out(tx_clock_mode_select_lvl)
  );

  // transmit mode from width select and clock mode
  always_comb
  begin
    mode_d = PAR_SLAVE;
    if (data_width_select_in) // parallel
    begin
      unique case (tx_clock_mode_select_lvl)
        LVL_LOW: mode_d = PAR_SLAVE;
        LVL_FLOAT: mode_d = PAR_LOOP;
        LVL_HIGH: mode_d = PAR_MASTER;
        default: mode_d = PAR_SLAVE;
      endcase
    end
    else
    begin
      unique case (tx_clock_mode_select_lvl)
        LVL_LOW: mode_d = SER_SYNC_CLK;
        LVL_FLOAT: mode_d = SER_SYNC_CDR;
        LVL_HIGH: mode_d = SER_PLESIO;
        default: mode_d = SER_SYNC_CLK;
      endcase
    end
  end

  // mode register and its clock steering outputs
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in) // low reset pin holds everything
    begin
      mode_q <= PAR_SLAVE;
      fifo_bypass_out <= 1'b0;
      par_clk_drive_out <= 1'b0;
      loop_timing_out <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      fifo_bypass_out <= (mode_d == SER_PLESIO);
      par_clk_drive_out <= (mode_d == PAR_MASTER);
      loop_timing_out <= (mode_d == PAR_LOOP);
    end
  end

  // fifo reset request per channel; none in plesiochronous serial
  always_comb
  begin
    fifo_phase_reset_req = '0;
    // mode_d follows the clock mode pin with the filter delay of the reset pin, so a joint change of those two pins cannot slip a pulse
    if (mode_d != SER_PLESIO)
    begin
      fifo_phase_reset_req[0] = (fifo_phase_reset_lvl == LVL_LOW);
      fifo_phase_reset_req[CHANNELS-1] = fifo_phase_reset_req[CHANNELS-1] | (fifo_phase_reset_lvl == LVL_HIGH);
    end
  end

  // common measurement window
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      win_q <= WIN_ZERO;
    else if (win_end)
      win_q <= WIN_ZERO;
    else
      win_q <= win_q + 1'b1;
  end
  assign win_end = (win_q == WIN_LAST);
  assign edge_all = {tx_clk_edge_in, rx_clk_edge_in};

  // per source edge count judged at window end
  for (genvar s = 0; s < NSRC; s++)
  begin : g_freq
    logic [WIN_W-1:0] cnt_q; // edges this window
    logic [WIN_W-1:0] cnt_inc; // count including this cycle's edge
    assign cnt_inc = cnt_q + WIN_W'(edge_all[s]);
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        cnt_q <= WIN_ZERO;
        lol_q[s] <= 1'b0;
      end
      else if (win_end)
      begin
        cnt_q <= WIN_ZERO; // closing cycle's edge is judged, not lost
        lol_q[s] <= (cnt_inc > EDGE_HI) || (cnt_inc < EDGE_LO);
      end
      else
        cnt_q <= cnt_inc;
    end
  end

  assign stat_rd = reg_rd_in && (reg_addr_in == STATUS_ADDR);

  // per channel fifo, loopback and interrupt logic
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    logic [FIFO_AW-1:0] wr_q; // write pointer
    logic [FIFO_AW-1:0] rd_q; // read pointer
    logic [FIFO_AW-1:0] wr_d;
    logic [FIFO_AW-1:0] rd_d;
    logic tx_lock_lost_bit; // tx lock lost now
    logic irq_set;
    logic irq_clr;

    tri_level_filter u_lpbk (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sense_pu_in(loopback_select_pu_in[c]),
      .sense_pd_in(loopback_select_pd_in[c]),
      .level_out(lpbk_lvl[c])
    );

    // loopback routing
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        remote_loopback_out[c] <= 1'b0;
        local_loopback_out[c] <= 1'b0;
      end
      else
      begin
        remote_loopback_out[c] <= (lpbk_lvl[c] == LVL_FLOAT);
        local_loopback_out[c] <= (lpbk_lvl[c] == LVL_HIGH);
      end
    end

    // pointer movement, frozen while bypassed
    always_comb
    begin
      wr_d = wr_q;
      rd_d = rd_q;
      if (!fifo_bypass_out)
      begin
        if (fifo_wr_in[c])
          wr_d = wr_q + 1'b1;
        if (fifo_rd_in[c])
          rd_d = rd_q + 1'b1;
      end
    end

    // pointers, centred while held, resume from centre on release
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        wr_q <= WR_CENTRE;
        rd_q <= PTR_ZERO;
        fifo_phase_reset_q[c] <= 1'b0;
        fifo_err_q[c] <= 1'b0;
      end
      else
      begin
        fifo_phase_reset_q[c] <= fifo_phase_reset_req[c];
        if (fifo_phase_reset_req[c])
        begin
          wr_q <= WR_CENTRE;
          rd_q <= PTR_ZERO;
          fifo_err_q[c] <= 1'b0;
        end
        else
        begin
          wr_q <= wr_d;
          rd_q <= rd_d;
          if (!fifo_bypass_out && (wr_d == rd_d))
            fifo_err_q[c] <= 1'b1; // pointers collided
        end
      end
    end

    assign tx_lock_lost_bit = lol_q[CHANNELS + c];
    // raise on enabled rising events, default only tx lock loss
    assign irq_set = (irq_en_q[EN_TX_LOCK_LOST_BIT_BIT] && tx_lock_lost_bit && !tx_lock_lost_bit_prev_q[c])
                  || (irq_en_q[EN_FIFOERR_BIT] && fifo_err_q[c] && !err_prev_q[c]);
    // status read, fifo reset for fifo cause, or tx lock regained
    assign irq_clr = stat_rd || (fifo_phase_reset_req[c] && fifo_cause_q[c])
                  || (!tx_lock_lost_bit && tx_lock_lost_bit_prev_q[c]);

    // interrupt pending; a new event beats a release in the same cycle
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        irq_q[c] <= 1'b0;
        fifo_cause_q[c] <= 1'b0;
        tx_lock_lost_bit_prev_q[c] <= 1'b0;
        err_prev_q[c] <= 1'b0;
        tx_fault_irq_n_out[c] <= 1'b1;
        rx_fault_irq_n_out[c] <= 1'b1;
        los_q[c] <= 1'b0;
      end
      else
      begin
        tx_lock_lost_bit_prev_q[c] <= tx_lock_lost_bit;
        err_prev_q[c] <= fifo_err_q[c];
        los_q[c] <= rx_signal_lost_in[c];
        if (irq_set)
        begin
          irq_q[c] <= 1'b1;
          fifo_cause_q[c] <= irq_en_q[EN_FIFOERR_BIT] && fifo_err_q[c] && !err_prev_q[c];
          tx_fault_irq_n_out[c] <= 1'b0;
        end
        else if (irq_clr)
        begin
          irq_q[c] <= 1'b0;
          fifo_cause_q[c] <= 1'b0;
          tx_fault_irq_n_out[c] <= 1'b1;
        end
        rx_fault_irq_n_out[c] <= 1'b1; // reserved
      end
    end
  end

  // status and reset outputs
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rx_signal_lost_out <= '0;
      rx_lock_lost_out <= '0;
      fifo_phase_reset_out <= '0;
      tx_mode_out <= PAR_SLAVE;
    end
    else
    begin
      rx_signal_lost_out <= los_q;
      rx_lock_lost_out <= lol_q[CHANNELS-1:0];
      fifo_phase_reset_out <= fifo_phase_reset_q;
      tx_mode_out <= mode_q;
    end
  end

  // interrupt enable register
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_en_q <= IRQ_EN_RESET;
    else if (reg_wr_in && reg_addr_in == IRQ_EN_ADDR)
      irq_en_q <= reg_wdata_in[EN_W-1:0];
  end

  // read mux, unmapped reads give zero
  always_comb
  begin
    rdata_d = READ_ZERO;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        STATUS_ADDR:
          for (int c = 0; c < CHANNELS; c++)
          begin
            rdata_d[c*STAT_CH_STRIDE+STAT_LOS_BIT] = los_q[c];
            rdata_d[c*STAT_CH_STRIDE+STAT_LOL_BIT] = lol_q[c];
            rdata_d[c*STAT_CH_STRIDE+STAT_TX_LOCK_LOST_BIT_BIT] = lol_q[CHANNELS+c];
            rdata_d[c*STAT_CH_STRIDE+STAT_FIFOERR_BIT] = fifo_err_q[c];
            rdata_d[c*STAT_CH_STRIDE+STAT_IRQ_BIT] = irq_q[c];
          end
        IRQ_EN_ADDR:
          rdata_d[EN_W-1:0] = irq_en_q;
        MODE_ADDR:
        begin
          rdata_d[MODE_TXMODE_LSB +: 3] = mode_q;
          rdata_d[MODE_FIFO_PHASE_RESET_LSB +: 2] = fifo_phase_reset_lvl;
          for (int c = 0; c < CHANNELS; c++)
            rdata_d[MODE_LPBK_LSB + c*MODE_LPBK_STRIDE +: 2] = lpbk_lvl[c];
        end
        default:
          rdata_d = READ_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_q <= READ_ZERO;
    else
      rdata_q <= rdata_d;
  end
  assign reg_rdata_out = rdata_q;
endmodule // liu_pin_mode_status_control

//--- bench/liu_pin_mode_status_control_chk.sv
`timescale 1ns/1ns
module liu_pin_mode_status_control_chk
  import liu_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [CHANNELS-1:0] rx_signal_lost_in,
  input wire logic [CHANNELS-1:0] rx_signal_lost_out,
  input wire logic [CHANNELS-1:0] rx_fault_irq_n_out,
  input wire logic [CHANNELS-1:0] tx_fault_irq_n_out,
  input wire logic [CHANNELS-1:0] fifo_phase_reset_out,
  input wire logic [CHANNELS-1:0] remote_loopback_out,
  input wire logic [CHANNELS-1:0] local_loopback_out,
  input tx_mode_type tx_mode_out,
  input wire logic fifo_bypass_out,
  input wire logic par_clk_drive_out,
  input wire logic loop_timing_out
);
  logic [1:0] up_q; // edges since reset release, saturating
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // age counter keeps $past clear of reset values
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  a_rx_irq_idle: assert property (rx_fault_irq_n_out == '1)
    else $error("receive fault output left idle level");
  a_los_follow: assert property ((up_q == 2'h3) |->
    rx_signal_lost_out == $past(rx_signal_lost_in, 2))
    else $error("loss of signal output does not follow input");
  // steering outputs lead the mode output by one cycle
  a_bypass_plesio: assert property ((up_q != 2'h0) |->
    $past(fifo_bypass_out) == (tx_mode_out == SER_PLESIO))
    else $error("fifo bypass disagrees with transmit mode");
  a_master_drive: assert property ((up_q != 2'h0) |->
    $past(par_clk_drive_out) == (tx_mode_out == PAR_MASTER))
    else $error("parallel clock drive disagrees with transmit mode");
  a_loop_timing: assert property ((up_q != 2'h0) |->
    ($past(loop_timing_out) == (tx_mode_out == PAR_LOOP)) && !(loop_timing_out && par_clk_drive_out))
    else $error("loop timing disagrees with transmit mode");
  a_loop_exclusive: assert property ((remote_loopback_out & local_loopback_out) == '0)
    else $error("remote and local loopback both on");
  a_fifo_phase_reset_onehot: assert property ($onehot0(fifo_phase_reset_out))
    else $error("fifo reset on both channels");
  a_fifo_phase_reset_ignored: assert property (fifo_bypass_out [*3] |->
    fifo_phase_reset_out == '0)
    else $error("fifo reset acted in bypass mode");
  c_irq: cover property (tx_fault_irq_n_out != '1);
  c_local: cover property (local_loopback_out != '0);
  c_fifo_phase_reset: cover property (fifo_phase_reset_out != '0);
  c_bypass: cover property (fifo_bypass_out);
endmodule // liu_pin_mode_status_control_chk

bind liu_pin_mode_status_control liu_pin_mode_status_control_chk #(.CHANNELS(CHANNELS))
  i_liu_pin_mode_status_control_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .rx_signal_lost_in(rx_signal_lost_in), .rx_signal_lost_out(rx_signal_lost_out),
  .rx_fault_irq_n_out(rx_fault_irq_n_out), .tx_fault_irq_n_out(tx_fault_irq_n_out),
  .fifo_phase_reset_out(fifo_phase_reset_out), .remote_loopback_out(remote_loopback_out),
  .local_loopback_out(local_loopback_out), .tx_mode_out(tx_mode_out),
  .fifo_bypass_out(fifo_bypass_out), .par_clk_drive_out(par_clk_drive_out),
  .loop_timing_out(loop_timing_out));

//--- bench/liu_board_model.sv
`timescale 1ns/1ns
module liu_board_model
  import liu_pkg::*;
(
  input wire logic core_clk_in,
  input tri_level_type fifo_phase_reset_lvl_in,
  input tri_level_type ck_lvl_in,
  input tri_level_type lb0_lvl_in,
  input tri_level_type lb1_lvl_in,
  input wire logic [1:0] rx_slow_in,
  input wire logic [1:0] tx_slow_in,
  output logic [1:0] fifo_phase_reset_sense_out,
  output logic [1:0] ck_sense_out,
  output logic [1:0] lb_pu_out,
  output logic [1:0] lb_pd_out,
  output logic [1:0] rx_edge_out,
  output logic [1:0] tx_edge_out
);
  logic [2:0] tick_q = 3'h0; // phase of the line clocks
  logic [1:0] rx_q = 2'h3; // recovered clock ticks
  logic [1:0] tx_q = 2'h3; // transmit recovery ticks
  // strap as sense pair {pull-up, pull-down}: low 00, float 10, high 11
  always_comb
  begin
    fifo_phase_reset_sense_out = {fifo_phase_reset_lvl_in != LVL_LOW, fifo_phase_reset_lvl_in == LVL_HIGH};
    ck_sense_out = {ck_lvl_in != LVL_LOW, ck_lvl_in == LVL_HIGH};
    lb_pu_out = {lb1_lvl_in != LVL_LOW, lb0_lvl_in != LVL_LOW};
    lb_pd_out = {lb1_lvl_in == LVL_HIGH, lb0_lvl_in == LVL_HIGH};
    rx_edge_out = rx_q;
    tx_edge_out = tx_q;
  end
  // ticks match the reference; a slow channel drops one in eight
  always_ff @(posedge core_clk_in)
  begin
    tick_q <= tick_q + 3'h1;
    rx_q <= ~(rx_slow_in & {2{tick_q == 3'h0}});
    tx_q <= ~(tx_slow_in & {2{tick_q == 3'h0}});
  end
endmodule // liu_board_model

//--- bench/test_liu_pin_mode_status_control.sv
`timescale 1ns/1ns
module test_liu_pin_mode_status_control;
  import liu_pkg::*;
  localparam int WIN = 1000; // shortened lock window
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  tri_level_type fifo_phase_reset_lvl = LVL_FLOAT, ck_lvl = LVL_FLOAT, lb0_lvl = LVL_LOW, lb1_lvl = LVL_LOW;
  logic width = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0] los = 2'h0, rx_slow = 2'h0, tx_slow = 2'h0, f_wr = 2'h0, f_rd = 2'h0;
  logic [1:0] fifo_phase_reset_s, ck_s, lb_pu, lb_pd, rx_edge, tx_edge;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0000_0000, rdata, rd_seen;
  logic [1:0] los_o, lol_o, txi_o, rxi_o, fifo_phase_reset_o, rem_o, loc_o;
  tx_mode_type mode_o;
  logic byp_o, pdrv_o, loopt_o;
  int bad_count = 0, samples_checked = 0;
  always #20 core_clk = ~core_clk;

  liu_pin_mode_status_control #(.WIN_CYCLES(WIN), .EXPECT_EDGES(WIN))
    i_liu_pin_mode_status_control (.core_clk_in(core_clk), .rstn_in(rstn),
    .fifo_phase_reset_pu_in(fifo_phase_reset_s[1]), .fifo_phase_reset_pd_in(fifo_phase_reset_s[0]),
    .tx_clock_mode_select_pu_in(ck_s[1]), .tx_clock_mode_select_pd_in(ck_s[0]),
    .loopback_select_pu_in(lb_pu), .loopback_select_pd_in(lb_pd), .data_width_select_in(width),
    .rx_signal_lost_in(los), .rx_clk_edge_in(rx_edge), .tx_clk_edge_in(tx_edge),
    .fifo_wr_in(f_wr), .fifo_rd_in(f_rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_signal_lost_out(los_o),
    .rx_lock_lost_out(lol_o), .tx_fault_irq_n_out(txi_o), .rx_fault_irq_n_out(rxi_o),
    .fifo_phase_reset_out(fifo_phase_reset_o), .remote_loopback_out(rem_o), .local_loopback_out(loc_o),
    .tx_mode_out(mode_o), .fifo_bypass_out(byp_o), .par_clk_drive_out(pdrv_o),
    .loop_timing_out(loopt_o));
  liu_board_model i_liu_board_model (.core_clk_in(core_clk), .fifo_phase_reset_lvl_in(fifo_phase_reset_lvl),
    .ck_lvl_in(ck_lvl), .lb0_lvl_in(lb0_lvl), .lb1_lvl_in(lb1_lvl), .rx_slow_in(rx_slow),
    .tx_slow_in(tx_slow), .fifo_phase_reset_sense_out(fifo_phase_reset_s), .ck_sense_out(ck_s), .lb_pu_out(lb_pu),
    .lb_pd_out(lb_pd), .rx_edge_out(rx_edge), .tx_edge_out(tx_edge));

  // compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    rd_seen = rdata;
  endtask
  // let n edges pass, then look where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // counts and verdict
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // expected transmit method from width and clock straps
  function automatic tx_mode_type exp_mode(input logic w, input tri_level_type l);
    if (w)
      return (l == LVL_LOW) ? PAR_SLAVE : (l == LVL_FLOAT) ? PAR_LOOP : PAR_MASTER;
    return (l == LVL_LOW) ? SER_SYNC_CLK : (l == LVL_FLOAT) ? SER_SYNC_CDR : SER_PLESIO;
  endfunction

  // hang guard, well beyond the expected run
  initial
  begin
    #(40 * 20000);
    bad_count++;
    summarize();
  end

  initial
  begin
    tx_mode_type em;
    // reset levels while held
    settle(3);
    check(DATA_W'({txi_o, rxi_o, fifo_phase_reset_o}), 32'h0000_003C);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    reg_read(IRQ_EN_ADDR);
    check(rd_seen, 32'h0000_0001);
    reg_read(4'hC);
    check(rd_seen, READ_ZERO);
    $display("test reset done");
    // loss of signal per channel
    for (int v = 0; v < 4; v++)
    begin
      @(posedge core_clk);
      los <= v[1:0];
      settle(3);
      check(DATA_W'(los_o), DATA_W'(v[1:0]));
    end
    $display("test los done");
    // every width and clock mode strap
    for (int w = 0; w < 2; w++)
      for (int k = 0; k < 3; k++)
      begin
        @(posedge core_clk);
        width <= w[0];
        ck_lvl <= tri_level_type'(k);
        settle(10);
        em = exp_mode(w[0], tri_level_type'(k));
        check(DATA_W'(mode_o), DATA_W'(em));
        check(DATA_W'({byp_o, pdrv_o, loopt_o}), DATA_W'({em == SER_PLESIO,
          em == PAR_MASTER, em == PAR_LOOP}));
        reg_read(MODE_ADDR);
        check(DATA_W'(rd_seen[MODE_TXMODE_LSB +: 3]), DATA_W'(em));
      end
    $display("test modes done");
    // loopback straps on both channels
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
      begin
        @(posedge core_clk);
        if (c == 0)
          lb0_lvl <= tri_level_type'(k % 3);
        else
          lb1_lvl <= tri_level_type'(k % 3);
        settle(10);
        check(DATA_W'({rem_o[c], loc_o[c]}), DATA_W'({k == 1, k == 2}));
        reg_read(MODE_ADDR);
        check(DATA_W'(rd_seen[MODE_LPBK_LSB + MODE_LPBK_STRIDE * c +: 2]),
          DATA_W'(k % 3));
      end
    $display("test loopback done");
    // phase reset pulse per channel after power-up, serial synchronous mode
    @(posedge core_clk);
    width <= 1'b0;
    ck_lvl <= LVL_LOW;
    // ends floating so the fifo runs for the collision below
    for (int k = 0; k < 5; k++)
    begin
      @(posedge core_clk);
      fifo_phase_reset_lvl <= tri_level_type'(k % 3);
      settle(10);
      check(DATA_W'(fifo_phase_reset_o), DATA_W'((k % 3 == 0) ? 2'h1 : (k % 3 == 2) ? 2'h2 : 2'h0));
    end
    // fifo collision raises the fault, phase reset clears it
    reg_write(IRQ_EN_ADDR, 32'h0000_0003);
    repeat (4)
    begin
      @(posedge core_clk);
      f_wr <= 2'h1;
      @(posedge core_clk);
      f_wr <= 2'h0;
    end
    settle(4);
    check(DATA_W'(txi_o), 32'h0000_0002);
    @(posedge core_clk);
    fifo_phase_reset_lvl <= LVL_LOW;
    settle(10);
    check(DATA_W'({txi_o, fifo_phase_reset_o}), 32'h0000_000D);
    reg_read(STATUS_ADDR);
    check(DATA_W'(rd_seen[STAT_FIFOERR_BIT]), 32'h0000_0000);
    @(posedge core_clk);
    fifo_phase_reset_lvl <= LVL_FLOAT;
    settle(10);
    check(DATA_W'(fifo_phase_reset_o), 32'h0000_0000);
    // phase reset ignored in plesiochronous mode
    @(posedge core_clk);
    ck_lvl <= LVL_HIGH;
    fifo_phase_reset_lvl <= LVL_LOW;
    settle(10);
    check(DATA_W'(fifo_phase_reset_o), 32'h0000_0000);
    @(posedge core_clk);
    fifo_phase_reset_lvl <= LVL_FLOAT;
    ck_lvl <= LVL_LOW;
    reg_write(IRQ_EN_ADDR, 32'h0000_0001);
    $display("test fifo done");
    // lock loss on receive ch1 and transmit ch0
    reg_read(STATUS_ADDR);
    @(posedge core_clk);
    rx_slow <= 2'h2;
    tx_slow <= 2'h1;
    los <= 2'h0;
    settle(2 * WIN + 10);
    check(DATA_W'(lol_o), 32'h0000_0002);
    check(DATA_W'(txi_o), 32'h0000_0002);
    reg_read(STATUS_ADDR);
    check(rd_seen, 32'h0000_0214);
    check(DATA_W'(txi_o), 32'h0000_0003);
    @(posedge core_clk);
    rx_slow <= 2'h0;
    tx_slow <= 2'h0;
    settle(2 * WIN + 10);
    check(DATA_W'({lol_o, txi_o}), 32'h0000_0003);
    $display("test lock done");
    summarize();
  end
endmodule // test_liu_pin_mode_status_control
